// ### hdl/htf_top.sv
`timescale 1ns/10ps
`include "htf_regs.svh"
module htf_top
    import htf_pkg::*;
#(
    parameter int PTR_W = 16
) (
    input wire logic CORE_CLK, // System clock
    input wire logic RST_B, // Chip reset
    input wire logic HOST_CS_B, // Host chip select pin
    input wire logic HOST_RD_B, // Host read strobe pin
    input wire logic HOST_WR_B, // Host write strobe pin
    input wire logic [3:0] HOST_ADDR, // Host register address pins
    input wire logic [7:0] HOST_DIN, // Host data bus in
    input wire logic HOST_BUS_RESET, // Host reset pin
    output logic [7:0] HOST_DOUT, // Host data bus out
    output logic [7:0] HOST_DOE, // Per-bit data drive enable
    output logic HOST_IRQ_OUT, // Host interrupt level
    output logic HOST_IRQ_OE, // Host interrupt drive enable
    output logic HOST_DMA_GATE, // Host DMA channel enable
    output logic HOST_IF_RESET, // Host interface reset, also to chained drive
    output logic CMD_START, // New command pulse
    output logic XFER_ABORT, // Abort transfer pulse
    output logic [7:0] CMD_CODE, // Last command byte
    output logic [7:0] STATUS_VIEW, // Status byte as host sees it
    input wire logic BUSY_CLR, // Firmware clears busy
    input wire logic [6:0] DRIVE_STAT, // Status bits 6..0, bit3 is transfer request
    input wire logic HOST_IRQ_REQ, // Firmware raises host interrupt
    input wire logic [7:0] DRIVE_HEAD, // Drive/head task register
    input wire logic [7:0] DRV0_CTL, // Drive 0 control register
    input wire logic [7:0] DRV1_CTL, // Drive 1 control register
    input wire logic [7:0] FEAT_CTL, // Feature control register
    input wire logic [7:0] MODE_CTL, // Host mode register
    input wire logic WRITE_GATE, // Live write gate to drive
    input wire logic [PTR_W-1:0] STOP_PTR, // Host stop pointer
    input wire logic [PTR_W-1:0] BUF_READ_PTR, // Buffer read pointer
    input wire logic [PTR_W-1:0] BUF_WRITE_PTR, // Buffer write pointer
    input wire logic XFER_IS_READ, // Read pointer is active
    input wire logic CHRDY_HOLD, // Device stalls host bus
    input wire logic [6:0] FMT_IRQ_STAT, // Formatter status bits
    input wire logic [7:0] MCU_ADDR, // Microcontroller address
    input wire logic MCU_RD, // Microcontroller read pulse
    output logic [7:0] MCU_RDATA, // Microcontroller read data
    output logic DMA_CTL_DONE // Done flag mirror
);

    htf_pin_t pin_in;
    htf_pin_t pin1_q;
    htf_pin_t pin2_q;
    logic hrst1_q;
    logic hrst2_q;
    logic rd3_q;
    logic wr3_q;
    logic cs3_q;
    logic [3:0] fd_q;
    logic [3:0] fd_d;
    logic busy_q;
    logic busy_d;
    logic irq_q;
    logic irq_d;
    logic eq_q;
    htf_events_t ev_q;
    htf_events_t ev_d;
    logic [7:0] dout_d;
    logic [7:0] doe_d;
    htf_rdsel_t rdsel;

    assign pin_in = '{cs_n: HOST_CS_B, rd_n: HOST_RD_B, wr_n: HOST_WR_B,
                      addr: HOST_ADDR, data: HOST_DIN};

    // Pins pass two flops before use
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin1_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
            pin2_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
            hrst1_q <= 1'b0;
            hrst2_q <= 1'b0;
            rd3_q <= 1'b1;
            wr3_q <= 1'b1;
            cs3_q <= 1'b1;
        end else begin
            pin1_q <= pin_in;
            pin2_q <= pin1_q;
            hrst1_q <= HOST_BUS_RESET;
            hrst2_q <= hrst1_q;
            rd3_q <= pin2_q.rd_n;
            wr3_q <= pin2_q.wr_n;
            cs3_q <= pin2_q.cs_n;
        end
    end

    wire xt_mode = MODE_CTL[`HTF_MODE_XT];
    wire transfer_request_flag = DRIVE_STAT[3];
    wire [3:0] a = pin2_q.addr;
    wire [7:0] wdata = pin2_q.data;
    // Strobe ends use chip select seen during the strobe
    wire wr_end = ~wr3_q & pin2_q.wr_n & ~cs3_q;
    wire rd_end = ~rd3_q & pin2_q.rd_n & ~cs3_q;
    wire rd_act = ~pin2_q.cs_n & ~pin2_q.rd_n;
    wire rd_start = rd_act & rd3_q;
    wire cmd_wr = wr_end & ~xt_mode & (a == `HTF_OFS_CMD);
    wire ctl_wr = wr_end & ~xt_mode & (a == `HTF_OFS_CTL);
    wire port1_wr = wr_end & xt_mode & (a == `HTF_OFS_PORT1);
    wire port2_wr = wr_end & xt_mode & (a == `HTF_OFS_PORT2);
    wire prog_rst = fd_q[`HTF_FD_RESET];
    wire host_rst = hrst2_q | prog_rst;
    wire rst_cond = host_rst | port1_wr;
    // Command taken only when idle or while data request is up
    wire cmd_take = cmd_wr & ~host_rst & (~busy_q | transfer_request_flag);
    wire abort = cmd_take & transfer_request_flag;
    wire [7:0] status = {busy_q, DRIVE_STAT};

    // Fixed-disk control; upper bits are don't care and not kept
    always_comb begin
        fd_d = fd_q;
        if (ctl_wr) begin
            fd_d = wdata[3:0];
        end
    end

    always_comb begin
        busy_d = busy_q;
        if (BUSY_CLR) begin
            busy_d = 1'b0;
        end
        if (host_rst | cmd_take) begin
            busy_d = 1'b1;
        end
    end

    // Host interrupt pending: set wins over the status-read clear
    always_comb begin
        irq_d = irq_q;
        if (rd_start & (rdsel == HTF_RD_STAT)) begin
            irq_d = 1'b0;
        end
        if (host_rst) begin
            irq_d = 1'b0;
        end
        if (HOST_IRQ_REQ) begin
            irq_d = 1'b1;
        end
    end

    // Read source; alternate status leaves the interrupt alone
    assign rdsel = ~rd_act ? HTF_RD_NONE :
                   (~xt_mode & (a == `HTF_OFS_CMD)) ? HTF_RD_STAT :
                   (~xt_mode & (a == `HTF_OFS_CTL)) ? HTF_RD_ALT :
                   (~xt_mode & (a == `HTF_OFS_DIN)) ? HTF_RD_LOOP :
                   HTF_RD_NONE;

    // Loopback view, all negative true
    wire drv = DRIVE_HEAD[`HTF_DH_DRIVE];
    wire [7:0] drv_ctl = drv ? DRV1_CTL : DRV0_CTL;
    wire head3_view_select = fd_q[`HTF_FD_HEAD3] | drv_ctl[`HTF_DRV_CTL_HEAD3];
    wire drive_sel0_n = drv;
    wire drive_sel1_n = ~drv;
    wire [2:0] head_n = ~DRIVE_HEAD[2:0];
    wire head3_or_low_current_n = head3_view_select ? ~DRIVE_HEAD[`HTF_DH_HEAD3] :
                                  ~drv_ctl[`HTF_DRV_CTL_LOWCUR];
    wire write_gate_view_n = ~WRITE_GATE;
    wire [7:0] loopback = {1'b0, write_gate_view_n, head3_or_low_current_n,
                           head_n, drive_sel1_n, drive_sel0_n};

    always_comb begin
        case (rdsel)
            HTF_RD_STAT: begin
                dout_d = status;
                doe_d = 8'hff;
            end
            HTF_RD_ALT: begin
                dout_d = status;
                doe_d = 8'hff;
            end
            HTF_RD_LOOP: begin
                dout_d = loopback;
                doe_d = `HTF_DIN_DOE;
            end
            default: begin
                dout_d = 8'h00;
                doe_d = 8'h00;
            end
        endcase
    end

    // Event flags
    wire [PTR_W-1:0] act_ptr = XFER_IS_READ ? BUF_READ_PTR : BUF_WRITE_PTR;
    wire ptr_eq = (act_ptr == STOP_PTR);
    wire done_set = ptr_eq & ~eq_q;
    wire ovr_set = CHRDY_HOLD & (wr_end | rd_end);
    wire sel_set = xt_mode ? port2_wr : cmd_wr;
    wire mcu_clr = MCU_RD & (MCU_ADDR == `HTF_OFS_EVENTS);

    always_comb begin
        ev_d = ev_q;
        ev_d.fmt_any = |FMT_IRQ_STAT;
        if (mcu_clr) begin
            ev_d.done = 1'b0;
            ev_d.ovr_det = 1'b0;
            ev_d.sel_det = 1'b0;
            ev_d.rst_det = 1'b0;
        end
        if (done_set) begin
            ev_d.done = 1'b1;
        end
        if (ovr_set) begin
            ev_d.ovr_det = 1'b1;
        end
        if (sel_set) begin
            ev_d.sel_det = 1'b1;
        end
        if (host_rst) begin
            ev_d.done = 1'b0;
            ev_d.ovr_det = 1'b0;
            ev_d.sel_det = 1'b0;
        end
        if (rst_cond) begin
            ev_d.rst_det = 1'b1;
        end
    end

    // Chip reset clears everything; a held host reset sets bit4 again
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ev_q <= '0;
            eq_q <= 1'b0;
        end else begin
            ev_q <= ev_d;
            eq_q <= ptr_eq;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            fd_q <= `HTF_FD_RESET_VAL;
            busy_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            fd_q <= fd_d;
            busy_q <= busy_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            HOST_DOUT <= 8'h00;
            HOST_DOE <= 8'h00;
            HOST_IRQ_OUT <= 1'b0;
            HOST_IRQ_OE <= 1'b0;
            HOST_DMA_GATE <= 1'b0;
            HOST_IF_RESET <= 1'b1;
        end else begin
            HOST_DOUT <= dout_d;
            HOST_DOE <= doe_d;
            HOST_IRQ_OUT <= irq_q;
            HOST_IRQ_OE <= ~fd_q[`HTF_FD_IRQ_DIS];
            HOST_DMA_GATE <= fd_q[`HTF_FD_DMA] & FEAT_CTL[`HTF_FEAT_DMA_ALLOW]
                             & MODE_CTL[`HTF_MODE_DMA];
            HOST_IF_RESET <= host_rst;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CMD_START <= 1'b0;
            XFER_ABORT <= 1'b0;
            CMD_CODE <= 8'h00;
            STATUS_VIEW <= 8'h80;
            MCU_RDATA <= 8'h00;
            DMA_CTL_DONE <= 1'b0;
        end else begin
            CMD_START <= cmd_take;
            XFER_ABORT <= abort;
            if (cmd_take) begin
                CMD_CODE <= wdata;
            end
            STATUS_VIEW <= status;
            // Reserved bits 3, 5, 6 always zero
            // Summary bit follows the formatter flags live, not a cycle late
            MCU_RDATA <= mcu_clr ? {ev_d.fmt_any, 2'b00, ev_q.rst_det, 1'b0,
                                    ev_q.sel_det, ev_q.ovr_det, ev_q.done} : 8'h00;
            DMA_CTL_DONE <= ev_d.done;
        end
    end

endmodule

// ### inc/htf_pkg.sv
package htf_pkg;
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [3:0] addr;
        logic [7:0] data;
    } htf_pin_t;
    typedef struct packed {
        logic fmt_any;
        logic rst_det;
        logic sel_det;
        logic ovr_det;
        logic done;
    } htf_events_t;
    typedef enum logic [1:0] {
        HTF_RD_NONE = 2'b00,
        HTF_RD_STAT = 2'b01,
        HTF_RD_ALT = 2'b10,
        HTF_RD_LOOP = 2'b11
    } htf_rdsel_t;
endpackage

// ### inc/htf_regs.svh
// Function
// - Command write during data request aborts transfer
// - Alternate status mirrors status, keeps interrupt
// - Interrupt disable bit floats host interrupt
// - Programmed reset holds host interface reset
// - Head-three view select chooses loopback bit5
// - Loopback reads anytime, negative true, bit7 floats
// - Drive selects complementary from drive bit
// - Loopback bits 2-4 are inverted head bits
// - Loopback bit5 head3 or low current, inverted
// - Loopback bit6 is inverted write gate
// - Event flags clear on resets, bit4 special
// - Microcontroller read clears flags except bit7
// - Done flag sets on stop pointer match
// - Done flag mirrored in DMA control bit5
// - Overrun sets on strobe end while stalling
// - Reset flag sets and holds during reset
// - Bit7 is OR of formatter status bits
// - Host status read clears pending interrupt
// - Busy sets on command or programmed reset
`ifndef HTF_REGS_SVH
`define HTF_REGS_SVH
`define HTF_OFS_CMD 4'h7
`define HTF_OFS_CTL 4'he
`define HTF_OFS_DIN 4'hf
`define HTF_OFS_PORT1 4'h1
`define HTF_OFS_PORT2 4'h2
`define HTF_OFS_EVENTS 8'h50
`define HTF_FD_DMA 0
`define HTF_FD_IRQ_DIS 1
`define HTF_FD_RESET 2
`define HTF_FD_HEAD3 3
`define HTF_FEAT_DMA_ALLOW 4
`define HTF_MODE_DMA 3
`define HTF_MODE_XT 7
`define HTF_DRV_CTL_LOWCUR 3
`define HTF_DRV_CTL_HEAD3 4
`define HTF_DH_DRIVE 4
`define HTF_DH_HEAD3 3
`define HTF_DIN_DOE 8'h7f
`define HTF_FD_RESET_VAL 4'h0
`endif

// ### sim/htf_host_bfm.sv
`timescale 1ns/10ps
`include "htf_regs.svh"
module htf_host_bfm
    import htf_pkg::*;
(
    input wire logic clk, // Core clock
    output htf_pin_t pin // Host pins
);
    initial pin = {3'b111, 4'h0, 8'h5a};
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        pin.cs_n = 1'b0;
        pin.addr = a;
        if (wr) pin.data = (a == `HTF_OFS_CTL) ? {4'h0, d[3:0]} : d;
        pin.wr_n = !wr;
        pin.rd_n = wr;
        repeat (6) @(negedge clk);
        pin.wr_n = 1'b1;
        pin.rd_n = 1'b1;
        repeat (2) @(negedge clk);
        pin.cs_n = 1'b1;
        pin.data = ~pin.data; // Released bus must not keep the last byte
        repeat (3) @(negedge clk);
    endtask
endmodule

// ### sim/htf_top_chk.sv
`timescale 1ns/10ps
module htf_top_chk
    import htf_pkg::*;
(
    input wire logic CORE_CLK, // Clock
    input wire logic RST_B, // Reset
    input wire logic [7:0] HOST_DOE, // Enables
    input wire logic MCU_RD, // MCU read
    input wire logic [7:0] MCU_ADDR, // MCU address
    input wire logic [7:0] MCU_RDATA, // MCU data
    input wire logic [6:0] FMT_IRQ_STAT, // Formatter flags
    input wire logic HOST_BUS_RESET, // Host reset
    input wire logic HOST_IF_RESET, // Interface reset
    input wire logic CMD_START, // Command pulse
    input wire logic XFER_ABORT, // Abort pulse
    input wire logic [7:0] STATUS_VIEW, // Status
    input wire logic [6:0] DRIVE_STAT // Drive status
);
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);
    wire ev_rd = MCU_RD && MCU_ADDR == 8'h50;
    chk_doe_shape: assert property (HOST_DOE inside {8'h00, 8'h7f, 8'hff})
        else $error("bad data enable pattern");
    chk_rdata_idle: assert property (!$past(MCU_RD) |-> MCU_RDATA == 8'h00)
        else $error("mcu data without read");
    chk_reserved_zero: assert property (MCU_RDATA[3] == 1'b0 && MCU_RDATA[6:5] == 2'b00)
        else $error("reserved flag set");
    chk_fmt_or: assert property ($past(ev_rd) |-> MCU_RDATA[7] == $past(|FMT_IRQ_STAT))
        else $error("summary bit wrong");
    chk_if_reset: assert property (HOST_BUS_RESET [*4] |-> HOST_IF_RESET)
        else $error("interface not in reset");
    chk_rst_hold: assert property (HOST_BUS_RESET [*4] ##1 (HOST_BUS_RESET && ev_rd) |=> MCU_RDATA[4])
        else $error("reset flag not held");
    chk_busy_cmd: assert property (CMD_START |-> ##[0:2] STATUS_VIEW[7])
        else $error("busy not set by command");
    chk_abort_cause: assert property (XFER_ABORT |-> CMD_START && $past(DRIVE_STAT[3]))
        else $error("abort without request");
    cover property (XFER_ABORT);
    cover property (CMD_START && !XFER_ABORT);
    cover property (ev_rd ##1 MCU_RDATA[4]);
endmodule

// ### sim/htf_top_test.sv
`timescale 1ns/10ps
module htf_top_test;
    import htf_pkg::*;
    logic clk, rst_b, hrst, bclr, irq_req, wg, xrd, chrdy, mrd, iro, iroe, gate, ifr, cst, abt, done, rdp, mrp;
    logic [6:0] ds, fmt;
    logic [7:0] dh, d0, d1, feat, mode, maddr, dout, doe, code, sv, mdat, e;
    logic [15:0] sp, rp, wp;
    logic [7:0] q[$];
    htf_pin_t pin;
    int n_errors, checks, n_st, n_ab;
    htf_host_bfm i_host(.clk(clk), .pin(pin));
    htf_top i_dut(.CORE_CLK(clk), .RST_B(rst_b), .HOST_CS_B(pin.cs_n), .HOST_RD_B(pin.rd_n), .HOST_WR_B(pin.wr_n),
        .HOST_ADDR(pin.addr), .HOST_DIN(pin.data), .HOST_BUS_RESET(hrst), .HOST_DOUT(dout), .HOST_DOE(doe),
        .HOST_IRQ_OUT(iro), .HOST_IRQ_OE(iroe), .HOST_DMA_GATE(gate), .HOST_IF_RESET(ifr), .CMD_START(cst),
        .XFER_ABORT(abt), .CMD_CODE(code), .STATUS_VIEW(sv), .BUSY_CLR(bclr), .DRIVE_STAT(ds),
        .HOST_IRQ_REQ(irq_req), .DRIVE_HEAD(dh), .DRV0_CTL(d0), .DRV1_CTL(d1), .FEAT_CTL(feat), .MODE_CTL(mode),
        .WRITE_GATE(wg), .STOP_PTR(sp), .BUF_READ_PTR(rp), .BUF_WRITE_PTR(wp), .XFER_IS_READ(xrd),
        .CHRDY_HOLD(chrdy), .FMT_IRQ_STAT(fmt), .MCU_ADDR(maddr), .MCU_RD(mrd), .MCU_RDATA(mdat),
        .DMA_CTL_DONE(done));
    task automatic chk(input logic [7:0] s, x, input string w);
        checks++;
        if (s !== x) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", w, x, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic hw(input logic [3:0] a, input logic [7:0] d);
        i_host.acc(1'b1, a, d);
    endtask
    task automatic hr(input logic [3:0] a, input logic [7:0] x);
        q.push_back(x);
        i_host.acc(1'b0, a, x);
    endtask
    task automatic mr(input logic [7:0] x);
        q.push_back(x);
        mrd = 1'b1;
        @(negedge clk);
        mrd = 1'b0;
        @(negedge clk);
    endtask
    function automatic logic [7:0] lb(input logic f3);
        logic [7:0] c;
        c = dh[4] ? d1 : d0;
        return {1'b0, ~wg, (f3 | c[4]) ? ~dh[3] : ~c[3], ~dh[2:0], ~dh[4], dh[4]};
    endfunction
    always @(posedge clk) begin
        if (mrp) chk(mdat, q.pop_front(), "mcu data");
        if (!rdp && pin.rd_n) chk(dout & doe, q.pop_front(), "host data");
        if (cst) begin
            n_st <= n_st + 1;
            n_ab <= n_ab + int'(abt);
            e <= code;
        end
        mrp <= mrd;
        rdp <= pin.rd_n;
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        n_errors++;
        finish_test();
    end
    initial begin
        {rst_b, hrst, bclr, irq_req, wg, xrd, chrdy, mrd, ds, dh, d0, d1, feat, mode} = '0;
        {maddr, fmt, sp, rp, wp} = {8'h50, 7'h04, 16'h0010, 32'h0};
        void'($urandom(54199));
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        mr(8'h80);
        maddr = 8'h51;
        mr(8'h00);
        maddr = 8'h50;
        ds = 7'($urandom()) & 7'h77;
        {bclr, irq_req} = 2'b11;
        @(negedge clk);
        {bclr, irq_req} = 2'b00;
        @(negedge clk);
        hr(4'he, {1'b0, ds});
        chk(8'(iro), 8'h01, "irq kept");
        hr(4'h7, {1'b0, ds});
        chk(8'(iro), 8'h00, "irq cleared");
        hw(4'he, 8'hf2);
        chk(8'(iroe), 8'h00, "irq float");
        $display("status test end");
        for (int i = 0; i < 8; i++) begin
            {feat, mode} = {3'h0, i[1], 8'h0, i[2], 3'h0};
            hw(4'he, {7'h0, i[0]});
            chk(8'(gate), 8'(i == 7), "dma gate");
        end
        for (int i = 0; i < 8; i++) begin
            dh = 8'($urandom());
            d0 = 8'($urandom());
            d1 = 8'($urandom());
            wg = i[0];
            hw(4'he, {4'h0, i[1], 3'h0});
            hr(4'hf, lb(i[1]));
        end
        $display("gate and loopback test end");
        hw(4'h7, 8'h20);
        chk({n_st[3:0], n_ab[3:0]}, 8'h10, "cmd start");
        chk(e, 8'h20, "cmd code");
        hr(4'he, {1'b1, ds});
        hw(4'h7, 8'h30);
        chk({n_st[3:0], n_ab[3:0]}, 8'h10, "busy refusal");
        ds[3] = 1'b1;
        hw(4'h7, 8'h31);
        chk({n_st[3:0], n_ab[3:0]}, 8'h21, "abort");
        chk(e, 8'h31, "abort code");
        chk(sv, {1'b1, ds}, "status view");
        mr(8'h84);
        mr(8'h80);
        ds[3] = 1'b0;
        $display("command test end");
        wp = sp;
        repeat (3) @(negedge clk);
        chk(8'(done), 8'h01, "done mirror");
        mr(8'h81);
        chk(8'(done), 8'h00, "done clear");
        wp = 16'h0;
        chrdy = 1'b1;
        hr(4'he, {1'b1, ds});
        chrdy = 1'b0;
        mr(8'h82);
        fmt = 7'h00;
        mr(8'h00);
        fmt = 7'h04;
        mode = 8'h80;
        hw(4'h2, 8'h00);
        hw(4'h1, 8'h00);
        mode = 8'h00;
        mr(8'h94);
        $display("flag test end");
        hw(4'he, 8'h04);
        chk(8'(ifr), 8'h01, "prog reset");
        mr(8'h90);
        hw(4'he, 8'h00);
        chk(8'(ifr), 8'h00, "reset off");
        mr(8'h90);
        hrst = 1'b1;
        repeat (5) @(negedge clk);
        mr(8'h90);
        chk(8'(ifr), 8'h01, "host reset");
        hrst = 1'b0;
        $display("reset test end");
        repeat (10) @(negedge clk);
        finish_test();
    end
endmodule
bind htf_top htf_top_chk u_chk(.CORE_CLK(CORE_CLK), .RST_B(RST_B), .HOST_DOE(HOST_DOE), .MCU_RD(MCU_RD),
    .MCU_ADDR(MCU_ADDR), .MCU_RDATA(MCU_RDATA), .FMT_IRQ_STAT(FMT_IRQ_STAT), .HOST_BUS_RESET(HOST_BUS_RESET),
    .HOST_IF_RESET(HOST_IF_RESET), .CMD_START(CMD_START), .XFER_ABORT(XFER_ABORT), .STATUS_VIEW(STATUS_VIEW),
    .DRIVE_STAT(DRIVE_STAT));
